// ===== logic/rx_status_regs.sv
/*
 * Status register bank of the receiver: ratio, E buffer window, identity,
 * control port mode detection, address straps, emphasis pin and input select.
 * Assumes a host-side port decoder hands over register reads and writes as
 * one-cycle strobes with a 7-bit address; pins are synchronous to mclk_i.
 */
`timescale 1ns/1ps
module rx_status_regs (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register access strobes from the port decoder
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Control bits held elsewhere in the control registers
    input wire logic buffer_select_bit_i,
    input wire logic [2:0] input_select_field_i,
    // Receiver status
    input wire logic pll_locked_i,
    input wire logic ratio_update_i,
    input wire logic [7:0] rate_ratio_value_i,
    input wire logic [2:0] emphasis_code_i,
    // E buffer fill from the receiver
    input wire logic cbuf_wr_i,
    input wire logic ubuf_wr_i,
    input wire logic [4:0] buf_waddr_i,
    input wire logic [7:0] buf_wdata_i,
    // Receiver inputs and chosen stream
    input wire logic [6:0] receiver_inputs_i,
    output logic rx_stream_o,
    // Shared select pin and data pin
    input wire logic addr0_or_select_pin_i,
    input wire logic ctrl_data_pin_i,
    input wire logic spi_read_bit_i,
    input wire logic tw_drive_low_i,
    output logic ctrl_data_pin_o,
    output logic ctrl_data_pin_oe_o,
    // Emphasis pin, strap read at start-up
    input wire logic emphasis_flag_pin_i,
    output logic emphasis_flag_pin_o,
    output logic emphasis_flag_pin_oe_o,
    // Port mode and address
    output logic spi_mode_o,
    output logic port_enable_o,
    output logic [6:0] tw_address_o,
    output logic low_power_o
);
    // Port mode states, Gray coded
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_TWO_WIRE = 2'b01,
        ST_SPI = 2'b11
    } port_state_t;

    port_state_t state_q; // Port mode
    logic sel_prev_q; // Select pin last cycle
    logic address_bit_two_q; // Captured emphasis strap
    logic [7:0] ratio_q; // Held ratio
    logic [7:0] rdata_q; // Read data
    logic rvalid_q; // Read answer strobe
    logic [1:0] rsrc_q; // Read source select
    logic emphasis_flag_pin_q; // Emphasis output
    logic rx_q; // Selected stream
    logic [7:0] cbuf_rd; // Channel status buffer read
    logic [7:0] ubuf_rd; // User buffer read
    logic [4:0] buf_raddr; // Window index
    logic in_window; // Address inside buffer window
    logic sel_fall; // Falling edge on select pin

    localparam logic [1:0] SRC_REG = 2'h0;
    localparam logic [1:0] SRC_CBUF = 2'h1;
    localparam logic [1:0] SRC_UBUF = 2'h2;

    assign in_window = (addr_i >= rx_status_pkg::ADDR_BUF_FIRST) && (addr_i <= rx_status_pkg::ADDR_BUF_LAST);
    assign buf_raddr = 5'(addr_i - rx_status_pkg::ADDR_BUF_FIRST); // [R4]
    assign sel_fall = sel_prev_q && !addr0_or_select_pin_i;

    // Channel status E buffer
    status_buffer_mem u_cbuf (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .wr_en_i(cbuf_wr_i),
        .wr_addr_i(buf_waddr_i),
        .wr_data_i(buf_wdata_i),
        .rd_addr_i(buf_raddr),
        .rd_data_o(cbuf_rd)
    );

    // User data E buffer
    status_buffer_mem u_ubuf (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .wr_en_i(ubuf_wr_i),
        .wr_addr_i(buf_waddr_i),
        .wr_data_i(buf_wdata_i),
        .rd_addr_i(buf_raddr),
        .rd_data_o(ubuf_rd)
    );

    // Select pin history for edge detection
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= addr0_or_select_pin_i;
        end
    end

    // Port mode: strap cycle, then two-wire until a select falling edge
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_STRAP;
        end else begin
            case (state_q)
                ST_STRAP: begin
                    state_q <= ST_TWO_WIRE; // [R7]
                end
                ST_TWO_WIRE: begin
                    if (sel_fall) begin
                        state_q <= ST_SPI; // [R7]
                    end
                end
                ST_SPI: begin
                    state_q <= ST_SPI; // Mode holds until reset
                end
                default: begin
                    state_q <= ST_STRAP;
                end
            endcase
        end
    end

    // Capture the emphasis strap in the cycle after reset release
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            address_bit_two_q <= 1'b0;
        end else if (state_q == ST_STRAP) begin
            address_bit_two_q <= emphasis_flag_pin_i; // [R10]
        end
    end

    // Ratio holds the last value sampled while locked; writes never touch it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ratio_q <= 8'h00;
        end else if (ratio_update_i && pll_locked_i) begin
            ratio_q <= rate_ratio_value_i; // [R1] [R2] [R15]
        end
    end

    // Read decode; the buffer sources answer from their own registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_q <= rx_status_pkg::READ_IDLE;
            rsrc_q <= SRC_REG;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_i;
            if (rd_i) begin
                rsrc_q <= SRC_REG;
                if (addr_i == rx_status_pkg::ADDR_RATIO) begin
                    rdata_q <= ratio_q; // [R1]
                end else if (addr_i == rx_status_pkg::ADDR_IDENT) begin
                    rdata_q <= {rx_status_pkg::PART_CODE, rx_status_pkg::REVISION}; // [R6]
                end else if (in_window) begin
                    rsrc_q <= buffer_select_bit_i ? SRC_UBUF : SRC_CBUF; // [R5]
                end else begin
                    rdata_q <= rx_status_pkg::READ_IDLE;
                end
            end
        end
    end

    // Answer mux and strobe
    always_comb begin
        case (rsrc_q)
            SRC_CBUF: rdata_o = cbuf_rd; // [R4]
            SRC_UBUF: rdata_o = ubuf_rd; // [R4]
            default: rdata_o = rdata_q;
        endcase
    end
    assign rvalid_o = rvalid_q;

    // Emphasis output, low only for 50/15
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            emphasis_flag_pin_q <= 1'b1;
        end else begin
            emphasis_flag_pin_q <= (emphasis_code_i != rx_status_pkg::EMPHASIS_FLAG_PIN_50_15); // [R11]
        end
    end
    assign emphasis_flag_pin_o = emphasis_flag_pin_q;
    assign emphasis_flag_pin_oe_o = (state_q != ST_STRAP) && !reset_i;

    // Input multiplexer; codes above six select nothing
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rx_q <= 1'b0;
        end else if (int'(input_select_field_i) < rx_status_pkg::NUM_INPUTS) begin
            rx_q <= receiver_inputs_i[input_select_field_i]; // [R12]
        end else begin
            rx_q <= 1'b0;
        end
    end
    assign rx_stream_o = rx_q;

    // Data pin: SPI drives read data, two-wire only pulls low
    assign ctrl_data_pin_o = (state_q == ST_SPI) ? spi_read_bit_i : 1'b0; // [R9]
    assign ctrl_data_pin_oe_o = (state_q == ST_SPI) ? !addr0_or_select_pin_i // [R8]
                              : ((state_q == ST_TWO_WIRE) && tw_drive_low_i); // [R9]

    // Mode and address outputs
    assign spi_mode_o = (state_q == ST_SPI);
    assign port_enable_o = (state_q == ST_SPI) ? !addr0_or_select_pin_i : (state_q == ST_TWO_WIRE); // [R8]
    assign tw_address_o = {rx_status_pkg::TW_ADDR_HI, address_bit_two_q, 1'b0, addr0_or_select_pin_i}; // [R9] [R10]
    assign low_power_o = reset_i; // [R13]

    // Ratio changes only while locked
    property p_ratio_locked;
        @(posedge mclk_i) disable iff (reset_i)
        !pll_locked_i |=> $stable(ratio_q);
    endproperty
    a_ratio_locked: assert property (p_ratio_locked) else $error("ratio changed while unlocked"); // [R2]

    // Writes leave ratio untouched
    property p_ratio_wr;
        @(posedge mclk_i) disable iff (reset_i)
        (wr_i && !ratio_update_i) |=> $stable(ratio_q);
    endproperty
    a_ratio_wr: assert property (p_ratio_wr) else $error("write altered ratio"); // [R15]

    // Ratio read returns held value
    property p_ratio_rd;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_i && addr_i == rx_status_pkg::ADDR_RATIO) |=> (rvalid_o && rdata_o == $past(ratio_q));
    endproperty
    a_ratio_rd: assert property (p_ratio_rd) else $error("ratio read wrong"); // [R1]

    // Identity read
    property p_ident;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_i && addr_i == rx_status_pkg::ADDR_IDENT) |=>
            (rdata_o == {rx_status_pkg::PART_CODE, rx_status_pkg::REVISION});
    endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong"); // [R6]

    // Window source follows buffer select
    property p_window;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_i && in_window) |=> (rsrc_q == ($past(buffer_select_bit_i) ? SRC_UBUF : SRC_CBUF));
    endproperty
    a_window: assert property (p_window) else $error("window source wrong"); // [R4] [R5]

    // Select falling edge in two-wire mode enters SPI
    sequence s_fall_in_tw;
        (state_q == ST_TWO_WIRE) && sel_fall;
    endsequence
    property p_spi_entry;
        @(posedge mclk_i) disable iff (reset_i)
        s_fall_in_tw |=> spi_mode_o [*2];
    endproperty
    a_spi_entry: assert property (p_spi_entry) else $error("SPI mode not entered"); // [R7]

    // No edge, no SPI
    property p_stay_tw;
        @(posedge mclk_i) disable iff (reset_i)
        ((state_q == ST_TWO_WIRE) && !sel_fall) |=> !spi_mode_o;
    endproperty
    a_stay_tw: assert property (p_stay_tw) else $error("left two-wire without edge"); // [R7]

    // Two-wire data pin only drives low, and only when asked to
    property p_open_drain;
        @(posedge mclk_i) disable iff (reset_i)
        !spi_mode_o |-> (!ctrl_data_pin_o && (!ctrl_data_pin_oe_o || tw_drive_low_i));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("two-wire pin driven high"); // [R9]

    // Emphasis follows code one cycle later
    property p_emphasis_flag_pin;
        @(posedge mclk_i) disable iff (reset_i)
        ##1 emphasis_flag_pin_o == ($past(emphasis_code_i) != rx_status_pkg::EMPHASIS_FLAG_PIN_50_15);
    endproperty
    a_emphasis_flag_pin: assert property (p_emphasis_flag_pin) else $error("emphasis output wrong"); // [R11]

    // Strap holds after capture
    property p_strap;
        @(posedge mclk_i) disable iff (reset_i)
        (state_q != ST_STRAP) |=> $stable(address_bit_two_q);
    endproperty
    a_strap: assert property (p_strap) else $error("address strap changed"); // [R10]
endmodule

// ===== shared/rx_status_pkg.sv
/*
 * Constants for the receiver status register bank and its control port.
 * Assumes a single 250 MHz clock domain and a synchronous active-high reset.
 */
// Behaviour
// (R1) Ratio register: integer 7:6, fraction 5:0
// (R2) Ratio valid only once PLL locked
// (R3) Host ignores ratio until lock, divides rates
// (R4) Address range exposes the E buffer window
// (R5) Buffer select: clear status, set user
// (R6) Identity register: part code, revision nibble
// (R7) Start two-wire; select falling edge gives SPI
// (R8) SPI: select enables port, read data out
// (R9) Two-wire: open-drain data, pin gives address bit0
// (R10) Emphasis pin strap gives address bit two
// (R11) Emphasis output low for 50/15 emphasis
// (R12) Three-bit select picks one of seven inputs
// (R13) Reset clears all state, low power
// (R14) Host holds reset until clocks stable
// (R15) Writes to read-only registers are ignored
package rx_status_pkg;
    // Register offsets
    localparam logic [6:0] ADDR_RATIO = 7'h1e;
    localparam logic [6:0] ADDR_BUF_FIRST = 7'h1f;
    localparam logic [6:0] ADDR_BUF_LAST = 7'h37;
    localparam logic [6:0] ADDR_IDENT = 7'h7f;
    // Buffer depth: bytes in the window
    localparam int BUF_DEPTH = 25;
    localparam int BUF_AW = 5;
    // Identity values, arbitrary
    localparam logic [3:0] PART_CODE = 4'ha;
    localparam logic [3:0] REVISION = 4'h3;
    // Emphasis code for 50/15 in channel status
    localparam logic [2:0] EMPHASIS_FLAG_PIN_50_15 = 3'h1;
    // Two-wire device address: fixed upper bits
    localparam logic [3:0] TW_ADDR_HI = 4'h2;
    // Number of receiver inputs
    localparam int NUM_INPUTS = 7;
    // Read data when nothing is mapped
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

// ===== logic/status_buffer_mem.sv
/*
 * Small memory that holds one E buffer; read data come from a register.
 * Assumes the receiver writes bytes one at a time on the same clock.
 */
`timescale 1ns/1ps
module status_buffer_mem (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Write side
    input wire logic wr_en_i,
    input wire logic [4:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read side
    input wire logic [4:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    // Storage array
    logic [7:0] mem_q [0:rx_status_pkg::BUF_DEPTH-1];
    logic [7:0] rd_q;

    // Write port; storage cleared by reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int i = 0; i < rx_status_pkg::BUF_DEPTH; i++) begin
                mem_q[i] <= 8'h00; // [R13]
            end
        end else if (wr_en_i && (int'(wr_addr_i) < rx_status_pkg::BUF_DEPTH)) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read port
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_q <= 8'h00;
        end else if (int'(rd_addr_i) < rx_status_pkg::BUF_DEPTH) begin
            rd_q <= mem_q[rd_addr_i];
        end else begin
            rd_q <= 8'h00;
        end
    end

    assign rd_data_o = rd_q;
endmodule

// ===== test/host_ctrl_model.sv
/*
 * Host controller model: register read and write strobes and control pins.
 * Assumes its tasks are entered just after a rising edge of mclk_i.
 */
`timescale 1ns/1ps
module host_ctrl_model (
    // Clock
    input wire logic mclk_i,
    // Register strobes to the block
    output logic rd_o,
    output logic wr_o,
    output logic [6:0] addr_o,
    output logic [7:0] wdata_o,
    // Control pins to the block
    output logic select_pin_o,
    output logic drive_low_o,
    output logic read_bit_o,
    // Answer from the block
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    // Idle: select high keeps the port in two-wire mode
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 7'h00;
        wdata_o = 8'h00;
        select_pin_o = 1'b1;
        drive_low_o = 1'b0;
        read_bit_o = 1'b0;
    end
    // One read; in SPI mode select is held low around it
    task automatic read_reg(input logic [6:0] a, input bit spi, output logic [7:0] d, output logic ok);
        @(posedge mclk_i);
        #1;
        if (spi) begin
            select_pin_o = 1'b0;
        end
        rd_o = 1'b1;
        addr_o = a;
        @(posedge mclk_i);
        #1;
        ok = rvalid_i;
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~a;
        if (spi) begin
            select_pin_o = 1'b1;
        end
    endtask
    // One write; released data is inverted so stale values never match
    task automatic write_reg(input logic [6:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = v;
        @(posedge mclk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~v;
    endtask
    // Set select, pull-low request and SPI read bit
    task automatic pins(input logic s, input logic l, input logic b);
        select_pin_o = s;
        drive_low_o = l;
        read_bit_o = b;
    endtask
endmodule

// ===== test/tb.sv
/*
 * Self-checking bench for the receiver status register bank.
 * Assumes a 250 MHz clock and a host model driving the register strobes.
 */
`timescale 1ns/1ps
module tb;
    // Block inputs, idle values at time zero
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic rd_i, wr_i, addr0_or_select_pin_i, spi_read_bit_i, tw_drive_low_i;
    logic [6:0] addr_i;
    logic [7:0] wdata_i;
    logic buffer_select_bit_i = 1'b0;
    logic [2:0] input_select_field_i = 3'h0;
    logic pll_locked_i = 1'b0;
    logic ratio_update_i = 1'b0;
    logic [7:0] rate_ratio_value_i = 8'h00;
    logic [2:0] emphasis_code_i = 3'h0;
    logic cbuf_wr_i = 1'b0;
    logic ubuf_wr_i = 1'b0;
    logic [4:0] buf_waddr_i = 5'h00;
    logic [7:0] buf_wdata_i = 8'h00;
    logic [6:0] receiver_inputs_i = 7'h00;
    logic strap = 1'b1;
    // Block outputs
    logic [7:0] rdata_o;
    logic rvalid_o, rx_stream_o, ctrl_data_pin_o, ctrl_data_pin_oe_o, emphasis_flag_pin_o;
    logic emphasis_flag_pin_oe_o, spi_mode_o, port_enable_o, low_power_o;
    logic [6:0] tw_address_o;
    // Wire levels: data line pulled up, emphasis pin strapped
    logic ctrl_data_pin_i;
    logic emphasis_flag_pin_i;
    assign ctrl_data_pin_i = ctrl_data_pin_oe_o ? ctrl_data_pin_o : 1'b1;
    assign emphasis_flag_pin_i = emphasis_flag_pin_oe_o ? emphasis_flag_pin_o : strap;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    rx_status_regs i_rx_status_regs (.mclk_i, .reset_i, .rd_i, .wr_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
        .buffer_select_bit_i, .input_select_field_i, .pll_locked_i, .ratio_update_i, .rate_ratio_value_i,
        .emphasis_code_i, .cbuf_wr_i, .ubuf_wr_i, .buf_waddr_i, .buf_wdata_i, .receiver_inputs_i, .rx_stream_o,
        .addr0_or_select_pin_i, .ctrl_data_pin_i, .spi_read_bit_i, .tw_drive_low_i, .ctrl_data_pin_o,
        .ctrl_data_pin_oe_o, .emphasis_flag_pin_i, .emphasis_flag_pin_o, .emphasis_flag_pin_oe_o, .spi_mode_o,
        .port_enable_o, .tw_address_o, .low_power_o);
    host_ctrl_model i_host_ctrl_model (.mclk_i, .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i),
        .select_pin_o(addr0_or_select_pin_i), .drive_low_o(tw_drive_low_i), .read_bit_o(spi_read_bit_i),
        .rdata_i(rdata_o), .rvalid_i(rvalid_o));
    // Clock, 4 ns period
    always #2 mclk_i = ~mclk_i;
    // Hang guard: tests need under a hundred cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    // Verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
            miscompares++;
        end
    endtask
    // Wait n edges, land just after the last
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Read through the host and compare
    task automatic rd_chk(input logic [6:0] a, input bit spi, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ok;
        i_host_ctrl_model.read_reg(a, spi, d, ok);
        chk(8'(ok), 8'h01, what);
        chk(d, exp, what);
    endtask
    // Reset with a strap level, then check the strap address
    task automatic do_reset(input logic s);
        reset_i = 1'b1;
        strap = s;
        tick(8);
        chk({3'h0, low_power_o, spi_mode_o, rvalid_o, emphasis_flag_pin_oe_o, emphasis_flag_pin_o}, 8'h11, "rst");
        reset_i = 1'b0;
        tick(1);
        chk({1'b0, tw_address_o}, {1'b0, rx_status_pkg::TW_ADDR_HI, s, 1'b0, 1'b1}, "twaddr");
        chk({6'h0, low_power_o, port_enable_o}, 8'h01, "awake");
    endtask
    // Identity register, write ignored
    task automatic t_ident();
        rd_chk(rx_status_pkg::ADDR_IDENT, 1'b0, {rx_status_pkg::PART_CODE, rx_status_pkg::REVISION}, "id");
        i_host_ctrl_model.write_reg(rx_status_pkg::ADDR_IDENT, 8'h55);
        rd_chk(rx_status_pkg::ADDR_IDENT, 1'b0, {rx_status_pkg::PART_CODE, rx_status_pkg::REVISION}, "id wr");
    endtask
    // Ratio sample offered with a lock state
    task automatic upd_ratio(input logic lk, input logic [7:0] v);
        pll_locked_i = lk;
        rate_ratio_value_i = v;
        ratio_update_i = 1'b1;
        tick(1);
        ratio_update_i = 1'b0;
    endtask
    // Ratio: integer 2 and 27/64 taken only while locked
    task automatic t_ratio();
        upd_ratio(1'b1, 8'h9b);
        rd_chk(rx_status_pkg::ADDR_RATIO, 1'b0, 8'h9b, "ratio");
        upd_ratio(1'b0, 8'h7f);
        rd_chk(rx_status_pkg::ADDR_RATIO, 1'b0, 8'h9b, "ratio unlk");
        i_host_ctrl_model.write_reg(rx_status_pkg::ADDR_RATIO, 8'h00);
        rd_chk(rx_status_pkg::ADDR_RATIO, 1'b0, 8'h9b, "ratio wr");
    endtask
    // Both buffers at the window ends, selected by the select bit
    task automatic t_buffer();
        for (int i = 0; i < 2; i++) begin
            buf_waddr_i = 5'(i * 24);
            buf_wdata_i = 8'(8'hc0 + i * 24);
            cbuf_wr_i = 1'b1;
            tick(1);
            cbuf_wr_i = 1'b0;
            buf_wdata_i = 8'(8'ha0 + i * 24);
            ubuf_wr_i = 1'b1;
            tick(1);
            ubuf_wr_i = 1'b0;
        end
        for (int b = 0; b < 2; b++) begin
            buffer_select_bit_i = b[0];
            for (int i = 0; i < 2; i++) begin
                rd_chk(7'(rx_status_pkg::ADDR_BUF_FIRST + i * 24), 1'b0, 8'((b ? 8'ha0 : 8'hc0) + i * 24), "buf");
            end
        end
        rd_chk(7'h38, 1'b0, rx_status_pkg::READ_IDLE, "unmapped");
    endtask
    // Emphasis pin low only for the 50/15 code
    task automatic t_emphasis_flag_pin();
        for (int c = 0; c < 8; c++) begin
            emphasis_code_i = 3'(c);
            tick(1);
            chk(8'(emphasis_flag_pin_i), 8'(c != int'(rx_status_pkg::EMPHASIS_FLAG_PIN_50_15)), "emphasis_flag_pin");
        end
    endtask
    // Every mux code with a one-hot input (all ones for code 7) and its inverse
    task automatic t_mux();
        for (int s = 0; s < 8; s++) begin
            input_select_field_i = 3'(s);
            receiver_inputs_i = (s < 7) ? 7'(1 << s) : 7'h7f;
            tick(1);
            chk(8'(rx_stream_o), 8'(s < 7), "mux hit");
            receiver_inputs_i = ~receiver_inputs_i;
            tick(1);
            chk(8'(rx_stream_o), 8'h00, "mux miss");
        end
    endtask
    // Two-wire open drain, then select falling edge into SPI
    task automatic t_port();
        i_host_ctrl_model.pins(1'b1, 1'b1, 1'b0);
        tick(1);
        chk({6'h0, ctrl_data_pin_i, ctrl_data_pin_oe_o}, 8'h01, "sda low");
        i_host_ctrl_model.pins(1'b1, 1'b0, 1'b1);
        tick(1);
        chk({5'h0, spi_mode_o, ctrl_data_pin_i, ctrl_data_pin_oe_o}, 8'h02, "sda rel");
        i_host_ctrl_model.pins(1'b0, 1'b0, 1'b1);
        tick(2);
        chk({4'h0, spi_mode_o, port_enable_o, ctrl_data_pin_oe_o, ctrl_data_pin_i}, 8'h0f, "spi 1");
        i_host_ctrl_model.pins(1'b0, 1'b0, 1'b0);
        tick(1);
        chk({4'h0, spi_mode_o, port_enable_o, ctrl_data_pin_oe_o, ctrl_data_pin_i}, 8'h0e, "spi 0");
        i_host_ctrl_model.pins(1'b1, 1'b0, 1'b0);
        tick(1);
        chk({5'h0, spi_mode_o, port_enable_o, ctrl_data_pin_oe_o}, 8'h04, "spi idle");
        rd_chk(rx_status_pkg::ADDR_IDENT, 1'b1, {rx_status_pkg::PART_CODE, rx_status_pkg::REVISION}, "spi rd");
    endtask
    // Main sequence, with a second reset in mid-run
    initial begin
        do_reset(1'b1);
        t_ident();
        t_ratio();
        t_buffer();
        t_emphasis_flag_pin();
        t_mux();
        t_port();
        do_reset(1'b0);
        t_ident();
        wrap_up();
    end
endmodule
